/* dv/ssp_peer_model.sv */
// Serial peripheral that exchanges a byte with the port when the port is master.
`timescale 1ns/1ps
`default_nettype none
module ssp_peer_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cke,
  input  wire logic [7:0] tx_byte,
  input  wire logic       load,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh_q;
  logic       first_q;
  assign miso = sh_q[7];
  // The first change edge of an edge-0 frame only presents the top bit, so it must not shift.
  always @(posedge load or sck) begin
    if (load) begin
      sh_q = tx_byte;
      first_q = 1'b1;
    end else if ((sck ^ cpol) == cke) begin
      rx_byte = {rx_byte[6:0], mosi};
      first_q = 1'b0;
    end else if (!first_q) begin
      sh_q = {sh_q[6:0], ~sh_q[0]};
    end
  end
endmodule
`default_nettype wire

/* dv/ssp_spi_port_chk.sv */
// Checker of the serial port's bus and pin behaviour.
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_port_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_data_out_oe,
  input wire logic        slave_select_pin_n,
  input wire logic        port_pins_owned,
  input wire logic        slave_select_owned,
  input wire logic        port_interrupt_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_w = psel && penable;
  wire map_w = paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00;
  sequence buf_wr_s;
    acc_w && pwrite && paddr == 12'h008 && serial_clock_pin_oe;
  endsequence
  sequence clk_move_s;
    ##[1:200] $changed(serial_clock_pin_out);
  endsequence
  ready_now_a: assert property (acc_w |-> pready) else $error("pready low in access");
  slverr_map_a: assert property (acc_w |-> pslverr == !map_w) else $error("pslverr wrong");
  pins_own_a: assert property (!port_pins_owned |-> !serial_clock_pin_oe && !serial_data_out_oe)
    else $error("pins driven while disabled");
  clk_rate_a: assert property (serial_clock_pin_oe && $changed(serial_clock_pin_out)
    |=> $stable(serial_clock_pin_out)) else $error("clock half period too short");
  start_shift_a: assert property (buf_wr_s |-> clk_move_s) else $error("no clock after write");
  sel_float_a: assert property ((slave_select_owned && slave_select_pin_n) [*4]
    |-> !serial_data_out_oe) else $error("data driven while deselected");
  flag_keep_a: assert property (port_interrupt_flag && !(acc_w && pwrite && paddr == 12'h00c)
    |=> port_interrupt_flag) else $error("interrupt flag lost");
  sel_owned_a: assert property (slave_select_owned |-> port_pins_owned) else $error("select owned");
endmodule
bind ssp_spi_port ssp_spi_port_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .serial_clock_pin_out, .serial_clock_pin_oe, .serial_data_out_oe,
  .slave_select_pin_n, .port_pins_owned, .slave_select_owned, .port_interrupt_flag);
`default_nettype wire

/* dv/test_sync_serial_spi_port.sv */
// Self-checking bench for the serial port in master and slave modes.
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_spi_port;
  import ssp_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rv, v, seed = 32'h2ae4;
  logic        period_timer_output = 1'b0, serial_clock_pin_in = 1'b0, sdi_tb = 1'b0;
  logic        slave_tb = 1'b0, slave_select_pin_n = 1'b1, cpol = 1'b0, cke = 1'b0, load = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, serial_clock_pin_out, serial_clock_pin_oe, serial_data_out;
  logic        serial_data_out_oe, port_pins_owned, slave_select_owned, port_interrupt_flag, miso;
  logic [7:0]  rx;
  logic [15:0] cyc = 16'h0;
  int          fail_count = 0, comparisons = 0, n;
  wire         serial_data_in = slave_tb ? sdi_tb : miso;
  ssp_spi_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .period_timer_output, .serial_clock_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe, .serial_data_in, .serial_data_out,
    .serial_data_out_oe, .slave_select_pin_n, .port_pins_owned, .slave_select_owned,
    .port_interrupt_flag);
  ssp_peer_model u_peer (.sck(serial_clock_pin_out), .mosi(serial_data_out), .cpol, .cke,
    .tx_byte(v[7:0]), .load, .miso, .rx_byte(rx));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 16'h1;
    period_timer_output <= cyc[2];
    if (cyc == 16'd40000) begin
      fail_count++;
      test_done();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] ctl(input logic [1:0] m, input logic p);
    return {3'b001, p, 2'b00, m};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = w ? {31'h0, pslverr} : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Slave frames use edge 1, polarity 0: data set up a half period before the rising edge.
  task automatic sbits(input logic [7:0] b, input int cnt);
    for (int k = 7; k > 7 - cnt; k--) begin
      sdi_tb <= b[k];
      repeat (8) @(posedge pclk);
      serial_clock_pin_in <= 1'b1;
      repeat (8) @(posedge pclk);
      serial_clock_pin_in <= 1'b0;
    end
  endtask
  task automatic test_done();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0); check(rv, 32'h0);
    apb(0, 12'h004, 0); check(rv, 32'h0);
    apb(1, 12'h010, 0); check(rv, 32'h1);
    apb(1, 12'h000, 8'hff); apb(0, 12'h000, 0); check(rv, 32'hc0);
    seed = xs(seed);
    apb(1, 12'h004, seed[7:0] & 8'hdf); apb(0, 12'h004, 0); check(rv, seed[7:0] & 8'hdf);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      v = seed;
      cpol <= i[2];
      cke <= i[0] ^ i[1];
      apb(1, 12'h004, 8'h00);
      apb(1, 12'h000, {v[9], i[0] ^ i[1], 6'h0});
      apb(1, 12'h004, ctl(i[1:0], i[2]));
      @(posedge pclk);
      @(negedge pclk);
      check(serial_clock_pin_out, i[2]);
      check(serial_clock_pin_oe, 1'b1);
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      apb(1, 12'h008, v[23:16]);
      apb(1, 12'h008, ~v[23:16]);
      n = 0;
      do begin
        apb(0, 12'h000, 0);
        n++;
      end while (rv[0] !== 1'b1 && n < 600);
      check(port_interrupt_flag, 1'b1);
      apb(0, 12'h004, 0); check(rv[7:6], 2'b10);
      apb(0, 12'h008, 0); check(rv, v[7:0]);
      check(rx, v[23:16]);
      apb(0, 12'h000, 0); check(rv[0], 1'b0);
      apb(1, 12'h00c, 8'h01); apb(0, 12'h000, 0); check(port_interrupt_flag, 1'b0);
      $display("master test %0d done", i);
    end
    apb(1, 12'h004, 8'h00);
    apb(1, 12'h000, 8'h40);
    apb(1, 12'h004, 8'h24);
    slave_tb <= 1'b1;
    slave_select_pin_n <= 1'b0;
    @(negedge pclk);
    check(serial_clock_pin_oe, 1'b0);
    sbits(8'ha5, 8); sbits(8'h3c, 8);
    check(serial_data_out_oe, 1'b1);
    apb(0, 12'h004, 0); check(rv[6], 1'b1);
    apb(0, 12'h008, 0); check(rv, 32'ha5);
    sbits(8'hf0, 4);
    slave_select_pin_n <= 1'b1;
    sdi_tb <= ~sdi_tb;
    repeat (6) @(posedge pclk);
    check(serial_data_out_oe, 1'b0);
    slave_select_pin_n <= 1'b0;
    sbits(8'h5a, 8);
    repeat (6) @(posedge pclk);
    apb(0, 12'h008, 0); check(rv, 32'h5a);
    $display("slave test done");
    test_done();
  end
endmodule
`default_nettype wire

/* src/ssp_params.svh */
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

`define SSP_OFS_STATUS    12'h000
`define SSP_OFS_CONTROL   12'h004
`define SSP_OFS_BUFFER    12'h008
`define SSP_OFS_EVENT     12'h00c

`define SSP_STAT_SMP      7
`define SSP_STAT_CKE      6
`define SSP_STAT_BF       0
`define SSP_CON_WRITE_COLLISION_FLAG      7
`define SSP_CON_OV        6
`define SSP_CON_EN        5
`define SSP_CON_CKP       4
`define SSP_EVT_IF        0

`define SSP_STATUS_RST    8'h00
`define SSP_CONTROL_RST   8'h00

`define SSP_DIV4_HALF     8'h02
`define SSP_DIV16_HALF    8'h08
`define SSP_DIV64_HALF    8'h20
`define SSP_BITS          4'h8

`endif

/* src/ssp_pkg.sv */
// Types shared by the serial port design.
package ssp_pkg;
  typedef enum logic [3:0] {
    SSP_M_DIV4   = 4'h0,
    SSP_M_DIV16  = 4'h1,
    SSP_M_DIV64  = 4'h2,
    SSP_M_TMR    = 4'h3,
    SSP_S_SEL    = 4'h4,
    SSP_S_NOSEL  = 4'h5
  } ssp_mode_type;
  typedef enum logic {
    SSP_IDLE,
    SSP_SHIFT
  } ssp_state_type;
endpackage

/* src/ssp_spi_port.sv */
// Serial port in SPI mode with an APB register slave.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"

module ssp_spi_port
  import ssp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        period_timer_output,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  input  wire logic        slave_select_pin_n,
  output logic             port_pins_owned,
  output logic             slave_select_owned,
  output logic             port_interrupt_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  logic [7:0]    status_q;
  logic [7:0]    control_q;
  logic [7:0]    buffer_q;
  logic [7:0]    shift_q;
  logic [3:0]    count_q;
  logic [7:0]    div_q;
  logic          sck_q;
  logic          sdo_q;
  logic          tmr_q;
  logic          tmr_half_q;
  logic          irq_q;
  logic [1:0]    sck_sync_q;
  logic [1:0]    ss_sync_q;
  logic          sck_prev_q;
  ssp_state_type state_q;

  wire access      = psel && penable;
  wire wr          = access && pwrite;
  wire rd          = access && !pwrite;
  wire hit_status  = paddr == `SSP_OFS_STATUS;
  wire hit_control = paddr == `SSP_OFS_CONTROL;
  wire hit_buffer  = paddr == `SSP_OFS_BUFFER;
  wire hit_event   = paddr == `SSP_OFS_EVENT;
  wire mapped      = hit_status || hit_control || hit_buffer || hit_event;
  wire lane0       = pstrb[0];

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = hit_status  ? {24'h000000, status_q} :
                   hit_control ? {24'h000000, control_q} :
                   hit_buffer  ? {24'h000000, buffer_q} :
                   hit_event   ? {31'h00000000, irq_q} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  wire       enable    = control_q[`SSP_CON_EN];
  wire       clock_polarity_bit       = control_q[`SSP_CON_CKP];
  wire       cke       = status_q[`SSP_STAT_CKE];
  wire       sample_phase_bit       = status_q[`SSP_STAT_SMP];
  wire [3:0] mode      = control_q[3:0];
  wire       is_master = mode[3:2] == 2'b00;
  wire       is_slave  = mode == SSP_S_SEL || mode == SSP_S_NOSEL;
  wire       sel_ctl   = mode == SSP_S_SEL;
  wire       ss_high   = sel_ctl && ss_sync_q[1];
  wire       mod_reset = !enable || ss_high;

  assign port_pins_owned      = enable;
  assign slave_select_owned   = enable && sel_ctl;
  assign serial_clock_pin_oe  = enable && is_master;
  assign serial_clock_pin_out = enable && is_master ? sck_q : clock_polarity_bit;
  assign serial_data_out      = sdo_q;
  // A selected slave releases the line two pclk cycles after select rises, even mid-byte.
  assign serial_data_out_oe   = enable && (is_master || (mode == SSP_S_NOSEL) ||
                                           (sel_ctl && !ss_sync_q[1]));
  assign port_interrupt_flag  = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Master clock generator: one enable pulse per half period.

  logic [7:0] half_len;
  always_comb begin
    unique case (mode)
      SSP_M_DIV16: half_len = `SSP_DIV16_HALF;
      SSP_M_DIV64: half_len = `SSP_DIV64_HALF;
      default:     half_len = `SSP_DIV4_HALF;
    endcase
  end

  wire tmr_rise  = period_timer_output && !tmr_q;
  wire div_done  = div_q == half_len - 8'h01;
  wire half_tick = (mode == SSP_M_TMR) ? tmr_rise : div_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      tmr_q <= 1'b0;
    end else begin
      tmr_q <= period_timer_output;
      div_q <= (state_q == SSP_IDLE || div_done) ? 8'h00 : div_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slave input synchronisers.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_sync_q <= 2'b00;
      ss_sync_q  <= 2'b11;
      sck_prev_q <= 1'b0;
    end else begin
      sck_sync_q <= {sck_sync_q[0], serial_clock_pin_in};
      ss_sync_q  <= {ss_sync_q[0], slave_select_pin_n};
      sck_prev_q <= sck_sync_q[1];
    end
  end

  wire s_edge      = sck_sync_q[1] != sck_prev_q;
  // Leading edge leaves idle level; trailing edge returns to it.
  wire s_lead      = s_edge && (sck_sync_q[1] != clock_polarity_bit);
  wire s_trail     = s_edge && (sck_sync_q[1] == clock_polarity_bit);
  wire slave_go    = enable && is_slave && !ss_high;

  ////////////////////////////////////////////////////////////////////////////////
  // Shift engine. In master mode sck_q toggles on half ticks; tmr_half_q marks
  // which half of a period is current.

  wire m_tick   = state_q == SSP_SHIFT && is_master && half_tick;
  wire m_lead   = m_tick && !tmr_half_q;
  wire m_trail  = m_tick && tmr_half_q;
  wire lead     = is_master ? m_lead : (slave_go && s_lead);
  wire trail    = is_master ? m_trail : (slave_go && s_trail);
  // Change edge: trailing with edge bit set, leading with it clear.
  wire chg      = cke ? trail : lead;
  wire smp_edge = cke ? lead : trail;
  wire last_bit = count_q == `SSP_BITS - 4'h1;
  // End-of-time sampling in master mode takes the bit on the next change edge.
  wire late     = is_master && sample_phase_bit;
  // With the edge bit clear the first change edge only re-presents the top bit.
  wire skip_chg = !cke && count_q == 4'h0;
  wire out_chg  = chg && !skip_chg;
  wire take     = late ? out_chg : smp_edge;
  wire done     = is_master ? (m_trail && last_bit)
                            : (smp_edge && last_bit);
  wire busy     = state_q == SSP_SHIFT;
  wire buf_wr   = wr && hit_buffer && lane0;
  wire collide  = buf_wr && busy;
  wire load     = buf_wr && !busy && enable;
  wire full     = status_q[`SSP_STAT_BF];
  wire overrun  = done && full && !is_master;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= SSP_IDLE;
      shift_q    <= 8'h00;
      count_q    <= 4'h0;
      sck_q      <= 1'b0;
      sdo_q      <= 1'b0;
      tmr_half_q <= 1'b0;
    end else if (mod_reset) begin
      state_q    <= SSP_IDLE;
      count_q    <= 4'h0;
      tmr_half_q <= 1'b0;
      sck_q      <= clock_polarity_bit;
    end else begin
      if (!busy)
        sck_q <= clock_polarity_bit;
      else if (m_tick)
        sck_q <= !sck_q;
      if (m_tick)
        tmr_half_q <= !tmr_half_q;
      if (load) begin
        shift_q <= pwdata[7:0];
        sdo_q   <= pwdata[7];
        count_q <= 4'h0;
        state_q <= SSP_SHIFT;
      end else begin
        if (is_slave && !busy && (s_lead || s_trail))
          state_q <= SSP_SHIFT;
        if (take)
          shift_q <= {shift_q[6:0], serial_data_in};
        if (out_chg)
          sdo_q <= late ? shift_q[6] : shift_q[7];
        if (smp_edge && !is_master || m_trail)
          count_q <= last_bit ? 4'h0 : count_q + 4'h1;
        if (done)
          state_q <= SSP_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status, control and receive buffer. Hardware sets win over software clears.

  // Only a master sampling on leading edges without end-of-time sampling has the whole byte before the end.
  wire [7:0] rx_byte = (is_master && !late && cke) ? shift_q
                                                   : {shift_q[6:0], serial_data_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q  <= `SSP_STATUS_RST;
      control_q <= `SSP_CONTROL_RST;
      buffer_q  <= 8'h00;
      irq_q     <= 1'b0;
    end else begin
      if (wr && hit_status && lane0)
        status_q[7:6] <= pwdata[7:6];
      if (wr && hit_control && lane0)
        control_q <= pwdata[7:0];
      if (wr && hit_event && lane0 && pwdata[`SSP_EVT_IF])
        irq_q <= 1'b0;
      if (rd && hit_buffer)
        status_q[`SSP_STAT_BF] <= 1'b0;
      if (load)
        buffer_q <= pwdata[7:0];
      if (collide)
        control_q[`SSP_CON_WRITE_COLLISION_FLAG] <= 1'b1;
      if (overrun)
        control_q[`SSP_CON_OV] <= 1'b1;
      if (done && !overrun) begin
        buffer_q               <= rx_byte;
        status_q[`SSP_STAT_BF] <= 1'b1;
      end
      if (done)
        irq_q <= 1'b1;
    end
  end

endmodule
`default_nettype wire
